//--- vcc_pkg.sv
// vcc_pkg: register map, field layout and constants of the capture channel control block
package vcc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] VCC_ADDR_CTRL0  = 8'h00;
  localparam logic [7:0] VCC_ADDR_CTRL1  = 8'h04;
  localparam logic [7:0] VCC_ADDR_STAT   = 8'h08;
  localparam logic [7:0] VCC_ADDR_IMASK  = 8'h0c;
  localparam logic [7:0] VCC_ADDR_ACTIVE = 8'h10;

  // ----------------------------------------------------------------
  // channel0_control field positions
  // ----------------------------------------------------------------
  localparam int VCC_RUN_BIT   = 0;
  localparam int VCC_MODE_LO   = 1;
  localparam int VCC_MODE_HI   = 2;
  localparam int VCC_ILV_BIT   = 3;
  localparam int VCC_LAYOUT_BIT = 4;
  localparam int VCC_FID_BIT   = 5;
  localparam int VCC_IRQS_LO   = 6;
  localparam int VCC_IRQS_HI   = 7;
  localparam int VCC_HDTV_BIT  = 8;

  // status / mask bits
  localparam int VCC_EV_FRAME  = 0;
  localparam int VCC_EV_LATCH  = 1;
  localparam int VCC_EV_W      = 2;

  localparam logic [8:0] VCC_CTRL0_RST = 9'h000;
  localparam logic [7:0] VCC_CTRL1_RST = 8'h00;
  localparam logic [1:0] VCC_EV_RST    = 2'h0;

  // frame interrupt select encodings
  localparam logic [1:0] VCC_IRQ_TOP  = 2'h0;
  localparam logic [1:0] VCC_IRQ_BOT  = 2'h1;
  localparam logic [1:0] VCC_IRQ_BOTH = 2'h2;

  // bit 1 of the capture data mode marks raw sensor capture
  localparam int VCC_MODE_RAW_BIT = 1;

  // axi responses
  localparam logic [1:0] VCC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VCC_RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {VCC_IDLE, VCC_ARMED} vcc_run_e;

endpackage : vcc_pkg

//--- vcc_ctrl.sv
// vcc_ctrl: channel 0 control register with axi4-lite access and frame events
`timescale 1ns/100ps
// Contract
// - frame irq select picks top (0), bottom (1h) or both (2h) fields; 3h reserved.
// - field id status loads 0 top, 1 bottom, only on channel 0 interrupt pulse outside raw sensor mode.
// - in raw sensor mode the field id status follows the incoming field id.
// - layout bit: 0 raster, 1 sub-picture; valid only for hdtv data.
// - blanking ancillary data always stored raster, sub-picture only for luma.
// - layout bit takes effect only in embedded-sync mode, ignored in raw mode.
// - interleave bit: 0 separate y and c streams, 1 multiplexed stream.
// - non-multiplexed mode starts only when both channel run bits are set.
// - non-multiplexed channel 0 forces channel 1 interleave bit to 1.
// - multiplexed embedded-sync mode lets each channel run independently.
// - capture mode 0-1h embedded-sync video, 2h-3h sensor with separate sync.
// - run bit 0 disables channel 0, 1 enables it.
// - after run is set, configuration latches at first vsync falling edge.
module vcc_ctrl
  import vcc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // video source pins
  input  wire logic        vid_vsync,
  input  wire logic        vid_field_id,
  // capture control outputs
  output logic             capture_active,
  output logic             capture_sub_picture,
  output logic             capture_interleave,
  output logic [1:0]       capture_mode,
  output logic             ch1_interleave,
  output logic             irq
);
  import vcc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic vs_sync;
  logic fid_now;
  logic vs_prev_q;
  vcc_sync2 #(
    .IDLE_LEVEL (1'b0)
  ) vs_sync_u (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (vid_vsync),
    .pin_sync (vs_sync)
  );
  vcc_sync2 #(
    .IDLE_LEVEL (1'b0)
  ) fid_sync_u (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (vid_field_id),
    .pin_sync (fid_now)
  );
  // previous synchronised level, reset to the idle level so no false edge follows reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vs_prev_q <= 1'b0;
    end else begin
      vs_prev_q <= vs_sync;
    end
  end
  wire vs_fall = vs_prev_q & ~vs_sync;
  wire vs_rise = ~vs_prev_q & vs_sync;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [8:0]          ctrl0_q;
  logic [7:0]          ctrl1_q;
  logic [VCC_EV_W-1:0] stat_q;
  logic [VCC_EV_W-1:0] mask_q;
  logic                fid_q;
  vcc_run_e            run_q;
  logic                act_q;
  logic                sub_q;
  logic                ilv_q;
  logic [1:0]          mode_q;
  logic                ch1_ilv_q;
  logic                irq_q;

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  logic       aw_q;
  logic       w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  wire aw_take = s_axi_awvalid & ~aw_q & ~bvalid_q;
  wire w_take  = s_axi_wvalid & ~w_q & ~bvalid_q;
  wire wr_go   = aw_q & w_q & ~bvalid_q;
  wire wr_c0   = wr_go & (awaddr_q == VCC_ADDR_CTRL0);
  wire wr_c1   = wr_go & (awaddr_q == VCC_ADDR_CTRL1);
  wire wr_st   = wr_go & (awaddr_q == VCC_ADDR_STAT);
  wire wr_mk   = wr_go & (awaddr_q == VCC_ADDR_IMASK);
  wire wr_ok   = wr_c0 | wr_c1 | wr_st | wr_mk | (wr_go & (awaddr_q == VCC_ADDR_ACTIVE));
  wire lane0   = wstrb_q[0];
  wire lane1   = wstrb_q[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= VCC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? VCC_RESP_OKAY : VCC_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register contents
  // ----------------------------------------------------------------
  wire [1:0] irq_sel  = ctrl0_q[VCC_IRQS_HI:VCC_IRQS_LO];
  wire [1:0] mode_sel = ctrl0_q[VCC_MODE_HI:VCC_MODE_LO];
  wire       raw_mode = mode_sel[VCC_MODE_RAW_BIT];
  wire       c0_run   = ctrl0_q[VCC_RUN_BIT];
  wire       c1_run   = ctrl1_q[VCC_RUN_BIT];
  wire       c0_ilv   = ctrl0_q[VCC_ILV_BIT];
  // both run bits needed for separate streams or sensor capture
  wire       need_both = ~c0_ilv | raw_mode;
  wire       start_ok  = c0_run & (~need_both | c1_run);
  // sub-picture only for hdtv luma in embedded-sync mode
  wire       sub_d     = ctrl0_q[VCC_LAYOUT_BIT] & ctrl0_q[VCC_HDTV_BIT]
                         & ~raw_mode;

  wire [7:0] wr_byte0 = wdata_q[7:0];
  // a channel 1 write cannot clear the forced interleave bit, not even for a cycle
  wire [7:0] c1_force = {7'h00, ~c0_ilv} << VCC_ILV_BIT;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_q <= VCC_CTRL0_RST;
      ctrl1_q <= VCC_CTRL1_RST;
      mask_q  <= VCC_EV_RST;
    end else begin
      if (wr_c0 && lane0) begin
        ctrl0_q[VCC_IRQS_HI:VCC_RUN_BIT] <= {wr_byte0[VCC_IRQS_HI:VCC_IRQS_LO],
                                             ctrl0_q[VCC_FID_BIT],
                                             wr_byte0[VCC_LAYOUT_BIT:VCC_RUN_BIT]};
      end
      if (wr_c0 && lane1) begin
        ctrl0_q[VCC_HDTV_BIT] <= wdata_q[VCC_HDTV_BIT];
      end
      if (wr_c1 && lane0) begin
        ctrl1_q <= wr_byte0 | c1_force;
      end else if (!c0_ilv) begin
        ctrl1_q[VCC_ILV_BIT] <= 1'b1;
      end
      if (wr_mk && lane0) begin
        mask_q <= wdata_q[VCC_EV_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // run sequencing and frame events
  // ----------------------------------------------------------------
  // latch configuration on the first vsync falling edge after run
  wire latch_ev = (run_q == VCC_IDLE) & start_ok & vs_fall;
  // frame pulse on vsync rise: field id picks top or bottom
  wire top_hit   = ~fid_now & ((irq_sel == VCC_IRQ_TOP) | (irq_sel == VCC_IRQ_BOTH));
  wire bot_hit   = fid_now & ((irq_sel == VCC_IRQ_BOT) | (irq_sel == VCC_IRQ_BOTH));
  wire frame_ev  = act_q & vs_rise & (top_hit | bot_hit);
  wire [VCC_EV_W-1:0] ev_set = {latch_ev, frame_ev};
  wire [VCC_EV_W-1:0] ev_clr = (wr_st && lane0) ? wdata_q[VCC_EV_W-1:0] : VCC_EV_RST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q     <= VCC_IDLE;
      act_q     <= 1'b0;
      sub_q     <= 1'b0;
      ilv_q     <= 1'b0;
      mode_q    <= 2'h0;
      ch1_ilv_q <= 1'b0;
      fid_q     <= 1'b0;
      stat_q    <= VCC_EV_RST;
      irq_q     <= 1'b0;
    end else begin
      unique case (run_q)
        VCC_IDLE: begin
          if (latch_ev) begin
            run_q  <= VCC_ARMED;
            act_q  <= 1'b1;
            sub_q  <= sub_d;
            ilv_q  <= c0_ilv;
            mode_q <= mode_sel;
          end
        end
        VCC_ARMED: begin
          if (!start_ok) begin
            run_q <= VCC_IDLE;
            act_q <= 1'b0;
          end
        end
      endcase
      ch1_ilv_q <= ctrl1_q[VCC_ILV_BIT];
      if (raw_mode) begin
        fid_q <= fid_now;
      end else if (frame_ev) begin
        fid_q <= fid_now;
      end
      stat_q <= (stat_q & ~ev_clr) | ev_set;
      irq_q  <= |(((stat_q & ~ev_clr) | ev_set) & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  logic        ar_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        rvalid_q;
  wire [31:0] rd_c0  = {23'h000000, ctrl0_q[VCC_HDTV_BIT], irq_sel, fid_q,
                        ctrl0_q[VCC_LAYOUT_BIT:VCC_RUN_BIT]};
  wire [31:0] rd_c1  = {24'h000000, ctrl1_q};
  wire [31:0] rd_st  = {30'h00000000, stat_q};
  wire [31:0] rd_mk  = {30'h00000000, mask_q};
  wire [31:0] rd_act = {27'h0000000, mode_q, ilv_q, sub_q, act_q};
  wire hit_c0  = s_axi_araddr == VCC_ADDR_CTRL0;
  wire hit_c1  = s_axi_araddr == VCC_ADDR_CTRL1;
  wire hit_st  = s_axi_araddr == VCC_ADDR_STAT;
  wire hit_mk  = s_axi_araddr == VCC_ADDR_IMASK;
  wire hit_act = s_axi_araddr == VCC_ADDR_ACTIVE;
  wire rd_hit  = hit_c0 | hit_c1 | hit_st | hit_mk | hit_act;
  wire [31:0] rd_mux = hit_c0 ? rd_c0 : hit_c1 ? rd_c1 : hit_st ? rd_st :
                       hit_mk ? rd_mk : hit_act ? rd_act : 32'h0000_0000;
  wire ar_take = s_axi_arvalid & ~rvalid_q & ~ar_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_q     <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= VCC_RESP_OKAY;
      rvalid_q <= 1'b0;
    end else begin
      ar_q <= ar_take;
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_hit ? VCC_RESP_OKAY : VCC_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready       = aw_q;
  assign s_axi_wready        = w_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = ar_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign capture_active      = act_q;
  assign capture_sub_picture = sub_q;
  assign capture_interleave  = ilv_q;
  assign capture_mode        = mode_q;
  assign ch1_interleave      = ch1_ilv_q;
  assign irq                 = irq_q;

endmodule : vcc_ctrl

// ----------------------------------------------------------------
// two-flop synchroniser for one pin
// ----------------------------------------------------------------
module vcc_sync2 #(
  // level held through reset, the idle level of the pin
  parameter logic IDLE_LEVEL = 1'b0
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pin and its synchronised level
  input  wire logic pin_in,
  output logic      pin_sync
);
  // only the second stage is read outside
  logic [1:0] sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q <= {2{IDLE_LEVEL}};
    end else begin
      sync_q <= {sync_q[0], pin_in};
    end
  end
  assign pin_sync = sync_q[1];

endmodule : vcc_sync2

//--- vcc_ctrl_chk.sv
// vcc_ctrl_chk: port assertions for the channel 0 control block
`timescale 1ns/100ps
module vcc_ctrl_chk
  import vcc_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register writes
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  // video and capture
  input wire logic        vid_vsync,
  input wire logic        capture_active,
  input wire logic        capture_sub_picture,
  input wire logic        capture_interleave,
  input wire logic [1:0]  capture_mode,
  input wire logic        ch1_interleave
);
  // --------
  // shadow of written control words
  // --------
  logic [8:0] c0_q;
  logic [7:0] c1_q;
  logic [7:0] since_fall_q;
  wire        wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c0_q <= VCC_CTRL0_RST;
      c1_q <= VCC_CTRL1_RST;
    end else if (wr_hit && s_axi_awaddr == VCC_ADDR_CTRL0) begin
      c0_q <= s_axi_wdata[8:0];
    end else if (wr_hit && s_axi_awaddr == VCC_ADDR_CTRL1) begin
      c1_q <= s_axi_wdata[7:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) since_fall_q <= 8'hff;
    else if ($fell(vid_vsync)) since_fall_q <= 8'h00;
    else if (since_fall_q != 8'hff) since_fall_q <= since_fall_q + 8'h01;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_mux_arm;
    c0_q[0] && c0_q[3] && !c0_q[2] && $fell(vid_vsync);
  endsequence
  sequence s_starts;
    ##[1:8] capture_active;
  endsequence
  property p_indep; s_mux_arm |-> s_starts; endproperty
  a_indep: assert property (p_indep)
    else $error("channel 0 did not start alone");
  property p_latch_cfg;
    $rose(capture_active) |-> capture_mode == c0_q[2:1] && capture_interleave == c0_q[3];
  endproperty
  a_latch_cfg: assert property (p_latch_cfg)
    else $error("latched config differs");
  property p_latch_edge; $rose(capture_active) |-> since_fall_q <= 8'd8; endproperty
  a_latch_edge: assert property (p_latch_edge)
    else $error("capture started away from vsync fall");
  property p_sub;
    $rose(capture_active) |-> capture_sub_picture == (c0_q[4] && c0_q[8] && !c0_q[2]);
  endproperty
  a_sub: assert property (p_sub)
    else $error("sub-picture latch wrong");
  property p_raw_sub; capture_active && capture_mode[1] |-> !capture_sub_picture; endproperty
  a_raw_sub: assert property (p_raw_sub)
    else $error("sub-picture in raw mode");
  property p_force; !c0_q[3] && !$past(c0_q[3]) |-> ##2 ch1_interleave; endproperty
  a_force: assert property (p_force)
    else $error("channel 1 interleave not forced");
  property p_stop; !c0_q[0] |-> ##2 !capture_active; endproperty
  a_stop: assert property (p_stop)
    else $error("capture active without run");
  property p_need_ch1; !c0_q[3] && !c1_q[0] |-> ##2 !capture_active; endproperty
  a_need_ch1: assert property (p_need_ch1)
    else $error("separate streams active without channel 1");
endmodule : vcc_ctrl_chk
bind vcc_ctrl vcc_ctrl_chk chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .vid_vsync, .capture_active,
  .capture_sub_picture, .capture_interleave, .capture_mode, .ch1_interleave);

//--- vcc_video_src.sv
// vcc_video_src: video source model driving vertical sync and field id
`timescale 1ns/100ps
module vcc_video_src (
  // sync pins
  output logic vid_vsync,
  output logic vid_field_id
);
  logic lclk = 1'b0;
  initial begin
    vid_vsync = 1'b0;
    vid_field_id = 1'b0;
  end
  always #160 lclk = ~lclk;
  // one sync pulse, field id settled a line ahead
  task automatic field(input logic f);
    @(posedge lclk);
    vid_field_id = f;
    @(posedge lclk);
    vid_vsync = 1'b1;
    repeat (4) @(posedge lclk);
    vid_vsync = 1'b0;
    repeat (3) @(posedge lclk);
  endtask : field
  task automatic set_field(input logic f);
    @(posedge lclk);
    vid_field_id = f;
  endtask : set_field
endmodule : vcc_video_src

//--- vcc_ctrl_tb.sv
// vcc_ctrl_tb: self-checking bench for the channel 0 control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, (e), (g)); end end
module vcc_ctrl_tb;
  import vcc_pkg::*;
  logic        aclk = 1'b0, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, capture_mode, br, rr;
  logic        vid_vsync, vid_field_id, capture_active, capture_sub_picture;
  logic        capture_interleave, ch1_interleave, irq, last_fid;
  int          err_count = 0, samples_checked = 0, cyc = 0;
  always #20 aclk = ~aclk;
  vcc_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .vid_vsync, .vid_field_id, .capture_active, .capture_sub_picture,
    .capture_interleave, .capture_mode, .ch1_interleave, .irq);
  vcc_video_src src_u (.vid_vsync, .vid_field_id);
  // --------
  // bus tasks
  // --------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // --------
  // scenarios
  // --------
  task automatic t_regs;
    rd(VCC_ADDR_CTRL0);
    `CHK("ctrl0 reset", 32'h0, rv)
    wr(8'h14, 32'h1);
    `CHK("unmapped bresp", VCC_RESP_SLVERR, br)
    rd(8'h14);
    `CHK("unmapped rresp", VCC_RESP_SLVERR, rr)
    s_axi_wstrb <= 4'h0;
    wr(VCC_ADDR_IMASK, 32'h3);
    `CHK("strobed-off bresp", VCC_RESP_OKAY, br)
    s_axi_wstrb <= 4'hf;
    rd(VCC_ADDR_IMASK);
    `CHK("strobed-off mask", 32'h0, rv)
    wr(VCC_ADDR_CTRL0, 32'hde);
    rd(VCC_ADDR_CTRL0);
    `CHK("ctrl0 readback", 9'h0de, rv[8:0])
  endtask : t_regs
  task automatic t_mux;
    wr(VCC_ADDR_CTRL0, 32'h19b);
    `CHK("idle before vsync", 1'b0, capture_active)
    src_u.field(1'b0);
    `CHK("mux alone", 1'b1, capture_active)
    `CHK("latched cfg", 4'h7, {capture_mode, capture_interleave, capture_sub_picture})
    src_u.field(1'b1);
    `CHK("masked irq", 1'b0, irq)
    rd(VCC_ADDR_STAT);
    `CHK("status", 2'h3, rv[1:0])
    rd(VCC_ADDR_CTRL0);
    `CHK("field id", 1'b1, rv[5])
    wr(VCC_ADDR_IMASK, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK("unmasked irq", 1'b1, irq)
  endtask : t_mux
  task automatic ev(input logic f, input logic e);
    src_u.field(f);
    if (e) last_fid = f;
    `CHK("frame irq", e, irq)
    rd(VCC_ADDR_STAT);
    `CHK("frame status", e, rv[0])
    rd(VCC_ADDR_CTRL0);
    `CHK("field id", last_fid, rv[5])
    wr(VCC_ADDR_STAT, 32'h3);
  endtask : ev
  task automatic t_sel;
    for (int s = 0; s < 4; s++) begin
      wr(VCC_ADDR_CTRL0, 32'h0);
      @(posedge aclk);
      `CHK("stopped", 1'b0, capture_active)
      wr(VCC_ADDR_CTRL0, 32'(s << 6) | 32'h9);
      src_u.field(1'b0);
      wr(VCC_ADDR_STAT, 32'h3);
      ev(1'b0, s == 0 || s == 2);
      ev(1'b1, s == 1 || s == 2);
    end
  endtask : t_sel
  task automatic t_nomux;
    wr(VCC_ADDR_CTRL1, 32'h0);
    repeat (2) @(posedge aclk);
    `CHK("ch1 copy", 1'b0, ch1_interleave)
    wr(VCC_ADDR_CTRL0, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK("ch1 forced", 1'b1, ch1_interleave)
    src_u.field(1'b0);
    `CHK("waits ch1", 1'b0, capture_active)
    wr(VCC_ADDR_CTRL1, 32'h1);
    src_u.field(1'b0);
    `CHK("both run", 1'b1, capture_active)
    wr(VCC_ADDR_CTRL1, 32'h0);
    repeat (2) @(posedge aclk);
    `CHK("ch1 stop", 1'b0, capture_active)
    wr(VCC_ADDR_CTRL0, 32'h0);
  endtask : t_nomux
  task automatic t_raw;
    wr(VCC_ADDR_CTRL1, 32'hd);
    wr(VCC_ADDR_CTRL0, 32'h11d);
    src_u.field(1'b1);
    `CHK("raw run", 1'b1, capture_active)
    `CHK("raw cfg", 3'h4, {capture_mode, capture_sub_picture})
    rd(VCC_ADDR_CTRL0);
    `CHK("raw field id high", 1'b1, rv[5])
    src_u.set_field(1'b0);
    repeat (4) @(posedge aclk);
    rd(VCC_ADDR_CTRL0);
    `CHK("raw field id", 1'b0, rv[5])
  endtask : t_raw
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test;
    end
  end
  initial begin
    aresetn       <= 1'b0;
    s_axi_awaddr  <= 8'h00;
    s_axi_araddr  <= 8'h00;
    s_axi_wdata   <= 32'h0000_0000;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    s_axi_bready  <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_mux;
    t_sel;
    t_nomux;
    t_raw;
    end_of_test;
  end
endmodule : vcc_ctrl_tb
